// ===== src/queue_and_lsu_interrupt_status.sv
// Operation
// - Status bits 15-0 latch one pending request per transmit descriptor queue.
// - Bits 31-16 of the queue status and clear registers read as zero.
// - Writing one to a queue clear bit clears that status bit, zero has no effect.
// - The unit status register is read-only; hardware events set its bits and writes to the unit clear register clear them.
// - Bit 31 sets when unit four lacks outbound credit at the requested priority.
// - Bit 30 sets on a retried doorbell or a refused test-and-swap from unit four.
// - Bit 29 sets when unit four drops a transaction on a DMA transfer error.
// - Bit 28 sets when unit four refuses an unsupported type or bad encoding.
// - Bit 27 sets when a non-posted unit four transaction gets an error response.
// - Bit 26 sets when unit four withholds a transaction under Xoff.
// - Bit 25 sets when a unit four transaction times out.
// - Bit 24 sets on clean completion from unit four only if its request enabled it.
// - Bits 23-16 report the same eight conditions for unit three in the same order.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module queue_and_lsu_interrupt_status
    import irq_status_pkg::*;
(
    // clock and reset
    input  wire logic                                clk_i,
    input  wire logic                                reset_i,
    // apb slave
    input  wire logic                                psel_i,
    input  wire logic                                penable_i,
    input  wire logic                                pwrite_i,
    input  wire logic [irq_status_pkg::ADDR_W-1:0]   paddr_i,
    input  wire logic [irq_status_pkg::DATA_W-1:0]   pwdata_i,
    input  wire logic [3:0]                          pstrb_i,
    output logic      [irq_status_pkg::DATA_W-1:0]   prdata_o,
    output logic                                     pready_o,
    output logic                                     pslverr_o,
    // queue requests, one-cycle pulses
    input  wire logic [irq_status_pkg::QUEUE_N-1:0]  queue_req_i,
    // unit three and four conditions, pulses, bit order as in the package
    input  wire logic [irq_status_pkg::UNIT_COND_N-1:0] unit_three_cond_i,
    input  wire logic [irq_status_pkg::UNIT_COND_N-1:0] unit_four_cond_i,
    // per request completion enables
    input  wire logic                                unit_three_request_control_i,
    input  wire logic                                unit_four_request_control_i,
    // interrupt
    output logic                                     irq_o
);
    import irq_status_pkg::*;

    // address decode
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] r);
        hit = (a[11:2] == r[11:2]);
    endfunction

    wire             access      = psel_i & penable_i;
    wire             wr_access   = access & pwrite_i;
    wire             full_word   = &pstrb_i;
    wire             hit_txq_st  = hit(paddr_i, TXQ_STATUS_ADDR);
    wire             hit_txq_clr = hit(paddr_i, TXQ_CLEAR_ADDR);
    wire             hit_unit_st  = hit(paddr_i, UNIT_STATUS_ADDR);
    wire             hit_unit_clr = hit(paddr_i, UNIT_CLEAR_ADDR);
    wire             hit_irq_st  = hit(paddr_i, IRQ_STATUS_ADDR);
    wire             hit_irq_en  = hit(paddr_i, IRQ_ENABLE_ADDR);
    wire             hit_irq_clr = hit(paddr_i, IRQ_CLEAR_ADDR);
    wire             mapped      = hit_txq_st | hit_txq_clr | hit_unit_st | hit_unit_clr
                                 | hit_irq_st | hit_irq_en | hit_irq_clr;
    // status registers that are read-only refuse writes
    wire             ro_write    = pwrite_i & (hit_unit_st | hit_irq_st);
    wire             bad_access  = ~mapped | ro_write;
    wire             wr_ok       = wr_access & ~bad_access & full_word;

    // queue status
    logic [QUEUE_N-1:0]  txq_bits;
    wire  [QUEUE_N-1:0]  txq_clear   = (wr_ok & (hit_txq_clr | hit_txq_st))
                                     ? pwdata_i[QUEUE_N-1:0] : '0;

    sticky_bits #(
        .WIDTH   (QUEUE_N)
    ) u_txq (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .set_i   (queue_req_i),
        .clear_i (txq_clear),
        .bits_o  (txq_bits)
    );

    // unit conditions; completion gated by the per request enable
    wire [UNIT_COND_N-1:0] unit3_set = {unit_three_cond_i[UNIT_COND_N-1:1],
        unit_three_cond_i[COND_DONE] & unit_three_request_control_i};
    wire [UNIT_COND_N-1:0] unit4_set = {unit_four_cond_i[UNIT_COND_N-1:1],
        unit_four_cond_i[COND_DONE] & unit_four_request_control_i};
    wire [DATA_W-1:0]      unit_set   = {unit4_set, unit3_set, 16'h0000};
    // only the dedicated clear register touches the read-only status
    wire [DATA_W-1:0]      unit_clear = (wr_ok & hit_unit_clr) ? pwdata_i : ZERO_WORD;
    logic [DATA_W-1:0]     unit_bits;
    logic [DATA_W-UNIT3_LSB-1:0] unit_hi;

    sticky_bits #(
        .WIDTH   (DATA_W-UNIT3_LSB)
    ) u_unit (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .set_i   (unit_set[DATA_W-1:UNIT3_LSB]),
        .clear_i (unit_clear[DATA_W-1:UNIT3_LSB]),
        .bits_o  (unit_hi)
    );
    assign unit_bits = {unit_hi, 16'h0000};

    // summary interrupt events
    logic [EV_N-1:0] ev_bits;
    logic [EV_N-1:0] ev_enable;
    wire  [EV_N-1:0] ev_set;
    assign ev_set[EV_TXQ]  = |queue_req_i;
    assign ev_set[EV_UNIT] = |unit_set;
    wire  [EV_N-1:0] ev_clear = (wr_ok & hit_irq_clr) ? pwdata_i[EV_N-1:0] : EV_RESET;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ev_bits   <= EV_RESET;
            ev_enable <= EV_RESET;
        end else begin
            ev_bits <= ev_set | (ev_bits & ~ev_clear);
            if (wr_ok & hit_irq_en) begin
                ev_enable <= pwdata_i[EV_N-1:0];
            end
        end
    end

    assign irq_o = |(ev_bits & ev_enable);

    // read mux
    wire [DATA_W-1:0] rd_data =
        hit_txq_st ? {16'h0000, txq_bits} :
        hit_unit_st ? unit_bits :
        hit_irq_st ? {30'h0000_0000, ev_bits} :
        hit_irq_en ? {30'h0000_0000, ev_enable} :
        ZERO_WORD;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            prdata_o <= ZERO_WORD;
        end else if (psel_i & ~penable_i & ~pwrite_i) begin
            prdata_o <= rd_data;
        end
    end

    assign pready_o  = 1'b1;
    assign pslverr_o = access & bad_access;

    // checks
    a_txq_set_holds: assert property (@(posedge clk_i) disable iff (reset_i)
        queue_req_i[0] |=> txq_bits[0])
        else $error("queue request not latched");
    a_txq_clear_one: assert property (@(posedge clk_i) disable iff (reset_i)
        (wr_ok && hit_txq_clr && pwdata_i[3] && !queue_req_i[3]) |=> !txq_bits[3])
        else $error("queue clear ignored");
    a_txq_clear_zero: assert property (@(posedge clk_i) disable iff (reset_i)
        (txq_bits[5] && !(wr_ok && (hit_txq_clr || hit_txq_st) && pwdata_i[5]))
        |=> txq_bits[5])
        else $error("queue bit lost without clear");
    a_txq_upper_zero: assert property (@(posedge clk_i) disable iff (reset_i)
        (psel_i && !penable_i && !pwrite_i && (hit_txq_st || hit_txq_clr))
        |=> prdata_o[31:16] == 16'h0000)
        else $error("reserved bits not zero");
    a_unit_ro_write: assert property (@(posedge clk_i) disable iff (reset_i)
        (wr_access && hit_unit_st && unit_set == 32'h0) |=> $stable(unit_bits))
        else $error("unit status written by software");
    a_unit4_credit: assert property (@(posedge clk_i) disable iff (reset_i)
        unit_four_cond_i[COND_NO_CREDIT] |=> unit_bits[31])
        else $error("credit bit not set");
    a_unit4_done_gate: assert property (@(posedge clk_i) disable iff (reset_i)
        (!unit_bits[24] && unit_four_cond_i[COND_DONE] && !unit_four_request_control_i)
        |=> !unit_bits[24])
        else $error("completion set while disabled");
    a_unit3_timeout: assert property (@(posedge clk_i) disable iff (reset_i)
        unit_three_cond_i[COND_TIMEOUT] |=> unit_bits[17])
        else $error("unit three timeout not set");
    a_unit_sticky: assert property (@(posedge clk_i) disable iff (reset_i)
        (unit_bits[26] && !(wr_ok && hit_unit_clr && pwdata_i[26])) |=> unit_bits[26])
        else $error("unit bit dropped");
endmodule // queue_and_lsu_interrupt_status

// ===== src/irq_status_pkg.sv
package irq_status_pkg;
    localparam int          DATA_W           = 32;
    localparam int          ADDR_W           = 12;
    localparam int          QUEUE_N          = 16;
    localparam int          UNIT_COND_N      = 8;
    localparam int          UNIT_N           = 2;
    // register byte addresses
    localparam logic [11:0] TXQ_STATUS_ADDR  = 12'h250;
    localparam logic [11:0] TXQ_CLEAR_ADDR   = 12'h258;
    localparam logic [11:0] UNIT_STATUS_ADDR = 12'h260;
    localparam logic [11:0] UNIT_CLEAR_ADDR  = 12'h268;
    localparam logic [11:0] IRQ_STATUS_ADDR  = 12'h270;
    localparam logic [11:0] IRQ_ENABLE_ADDR  = 12'h274;
    localparam logic [11:0] IRQ_CLEAR_ADDR   = 12'h278;
    // field positions
    localparam int          UNIT3_LSB        = 16;
    localparam int          UNIT4_LSB        = 24;
    localparam int          COND_NO_CREDIT   = 7;
    localparam int          COND_RETRY       = 6;
    localparam int          COND_DMA_ERR     = 5;
    localparam int          COND_BAD_TYPE    = 4;
    localparam int          COND_RESP_ERR    = 3;
    localparam int          COND_XOFF        = 2;
    localparam int          COND_TIMEOUT     = 1;
    localparam int          COND_DONE        = 0;
    // summary event bits
    localparam int          EV_TXQ           = 0;
    localparam int          EV_UNIT          = 1;
    localparam int          EV_N             = 2;
    // reset values
    localparam logic [31:0] STATUS_RESET     = 32'h0000_0000;
    localparam logic [1:0]  EV_RESET         = 2'h0;
    localparam logic [31:0] ZERO_WORD        = 32'h0000_0000;
endpackage

// ===== src/sticky_bits.sv
`timescale 1ns/1ps
module sticky_bits #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    // set and clear
    input  wire logic [WIDTH-1:0] set_i,
    input  wire logic [WIDTH-1:0] clear_i,
    // state
    output logic      [WIDTH-1:0] bits_o
);
    // set wins over a clear in the same cycle
    wire [WIDTH-1:0] next_bits = (bits_o & ~clear_i) | set_i;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            bits_o <= '0;
        end else begin
            bits_o <= next_bits;
        end
    end
endmodule // sticky_bits

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
    import irq_status_pkg::*;
    logic        clk_i = 1'b0, reset_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        ctl3 = 1'b0, ctl4 = 1'b0, irq, rdy, slverr, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [15:0] qreq = 16'h0;
    logic [7:0]  c3 = 8'h00, c4 = 8'h00;
    int          num_errors = 0, cmp_count = 0;
    always #20 clk_i = ~clk_i;
    queue_and_lsu_interrupt_status queue_and_lsu_interrupt_status_inst (
        .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF),
        .prdata_o(prdata), .pready_o(rdy), .pslverr_o(slverr), .queue_req_i(qreq),
        .unit_three_cond_i(c3), .unit_four_cond_i(c4),
        .unit_three_request_control_i(ctl3), .unit_four_request_control_i(ctl4),
        .irq_o(irq));
    task check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, result in r and err
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (rdy !== 1'b1 && n < 50);
        r = prdata;
        err = slverr;
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 50) begin
            num_errors++;
            wrap_up;
        end
    endtask
    task rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task pulse(input logic [15:0] q, input logic [7:0] a, input logic [7:0] b, input logic c);
        @(posedge clk_i);
        qreq <= q; c3 <= a; c4 <= b; ctl3 <= c; ctl4 <= c;
        @(posedge clk_i);
        qreq <= 16'h0; c3 <= 8'h00; c4 <= 8'h00;
    endtask
    task irq_is(input logic e);
        @(negedge clk_i);
        check({31'h0, irq}, {31'h0, e});
    endtask
    task t_reset;
        rd(12'h250); check(r, 32'h0000_0000);
        rd(12'h260); check(r, 32'h0000_0000);
        irq_is(1'b0);
    endtask
    task t_queue;
        pulse(16'hA5C3, 8'h00, 8'h00, 1'b0);
        rd(12'h250); check(r, 32'h0000_A5C3);
        apb(1'b1, 12'h258, 32'hFFFF_0003); check({31'h0, err}, 32'h0);
        rd(12'h258); check(r, 32'h0000_0000);
        rd(12'h250); check(r, 32'h0000_A5C0);
        apb(1'b1, 12'h258, 32'h0000_0000);
        apb(1'b1, 12'h250, 32'hFFFF_0000);
        rd(12'h250); check(r, 32'h0000_A5C0);
        apb(1'b1, 12'h258, 32'h0000_FFFF);
        rd(12'h250); check(r, 32'h0000_0000);
    endtask
    task t_units;
        for (int i = 0; i < 8; i++) begin
            pulse(16'h0, 8'h00, 8'(1 << i), 1'b1);
            rd(12'h260); check(r, 32'h1 << (24 + i));
            rd(12'h260); check(r, 32'h1 << (24 + i));
            apb(1'b1, 12'h268, 32'hFFFF_0000);
            pulse(16'h0, 8'(1 << i), 8'h00, 1'b1);
            rd(12'h260); check(r, 32'h1 << (16 + i));
            apb(1'b1, 12'h268, 32'hFFFF_0000);
            rd(12'h260); check(r, 32'h0000_0000);
        end
        pulse(16'h0, 8'h01, 8'h01, 1'b0);
        rd(12'h260); check(r, 32'h0000_0000);
        pulse(16'h0, 8'h81, 8'h81, 1'b1);
        apb(1'b1, 12'h260, 32'h0000_0000); check({31'h0, err}, 32'h1);
        rd(12'h260); check(r, 32'h8181_0000);
        apb(1'b1, 12'h268, 32'hFFFF_0000);
    endtask
    task t_irq;
        apb(1'b1, 12'h278, 32'h0000_0003);
        rd(12'h270); check(r, 32'h0000_0000);
        apb(1'b1, 12'h274, 32'h0000_0001);
        pulse(16'h0008, 8'h00, 8'h00, 1'b0);
        rd(12'h270); check(r, 32'h0000_0001);
        irq_is(1'b1);
        apb(1'b1, 12'h274, 32'h0000_0000);
        irq_is(1'b0);
        apb(1'b1, 12'h274, 32'h0000_0001);
        irq_is(1'b1);
        apb(1'b1, 12'h278, 32'h0000_0001);
        irq_is(1'b0);
        rd(12'h300); check({31'h0, err}, 32'h1);
        apb(1'b1, 12'h258, 32'h0000_FFFF);
        rd(12'h250); check(r, 32'h0000_0000);
    endtask
    task wrap_up;
        $display("Errors: %0d, comparisons: %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        t_reset;
        t_queue;
        t_units;
        t_irq;
        wrap_up;
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        num_errors++;
        wrap_up;
    end
endmodule // tb
